// ==== pfic_top.sv ====
// Functional notes
// RULE1 - MSI count per PF: 1 to 32
// RULE2 - MSI option shows capability on all PFs
// RULE3 - PF/VF table options; PF option on all PFs
// RULE4 - per-PF table parameters, shared by its VFs
// RULE5 - read-only 11-bit table size at [26:16]
// RULE6 - table offset qword aligned, read-only
// RULE7 - table BAR 0-5, or 0/2/4 for 64-bit
// RULE8 - pending array offset qword aligned, read-only
// RULE9 - pending array BAR 0-5, or 0/2/4
// RULE10 - legacy pins A-D on PFs only
// RULE11 - assert/deassert message per input change
// RULE12 - separate pins or one shared pin
// RULE13 - per-PF interrupt line 0-255 in message
// RULE14 - one message per level change only
`timescale 1ns/100ps
module pfic_top #(
	parameter int NUM_PF = 4
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// legacy interrupt requests from application logic
	input  wire logic        legacy_irq_a_request,
	input  wire logic        legacy_irq_b_request,
	input  wire logic        legacy_irq_c_request,
	input  wire logic        legacy_irq_d_request,
	// legacy message towards the link
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output logic             msg_assert,
	output logic [1:0]       msg_pin,
	output logic [7:0]       msg_line,
	output logic [1:0]       msg_func,
	// interrupt
	output logic             irq
);
	import pfic_pkg::*;

	if (NUM_PF < 1 || NUM_PF > PFIC_MAX_PF) begin : g_chk
		$error("pfic_top: NUM_PF must be 1 to 4");
	end

	logic [31:0] setup;
	logic [2:0]  msi_log2 [NUM_PF];
	logic [10:0] tbl_size [NUM_PF];
	logic [31:0] tbl_loc  [NUM_PF];
	logic [31:0] pba_loc  [NUM_PF];
	logic [1:0]  leg_pin  [NUM_PF];
	logic [7:0]  leg_line [NUM_PF];
	logic        leg_en   [NUM_PF];
	logic [PFIC_NUM_EV-1:0] ev_status;
	logic [PFIC_NUM_EV-1:0] ev_mask;
	logic [PFIC_NUM_EV-1:0] ev_set;
	logic [3:0]  req_meta;
	logic [3:0]  req_sync;
	logic [3:0]  wire_sent;
	logic [3:0]  wire_want;
	logic [1:0]  pin_func [PFIC_NUM_PINS];
	logic [1:0]  sel;
	logic        bar64;
	logic        wr_commit;
	logic        rd_commit;
	logic        refused;
	logic        hit;
	logic        busy_free;
	logic [1:0]  next_pin;
	logic        next_found;
	logic [31:0] next_rdata;
	logic        next_err;

	assign sel   = setup[PFIC_SEL_LSB +: 2];
	assign bar64 = setup[PFIC_BAR64_BIT];
	assign wr_commit = psel & penable & pready & pwrite;
	assign rd_commit = psel & penable & pready & ~pwrite;

	// RULE7 RULE9 bar check: 64-bit pairs need an even index
	function automatic logic bir_ok(input logic [2:0] b, input logic w64);
		bir_ok = (b <= PFIC_BIR_MAX) && !(w64 && b[0]);
	endfunction

	// one wait state keeps pready and prdata on flip-flops
	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			prdata  <= next_rdata;
			pslverr <= psel & penable & ~pready & next_err;
		end
	end

	// writes to the shared setup word
	always_ff @(posedge clk) begin
		if (srst) begin
			setup <= PFIC_SETUP_RST;
		end else if (wr_commit && paddr == PFIC_SETUP_OFS) begin
			setup <= {22'h000000, pwdata[9:0]};
		end
	end

	// per-function setup, addressed through the selected function
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_PF; i++) begin
				msi_log2[i] <= PFIC_MMC_RST;
				tbl_size[i] <= PFIC_TSIZE_RST;
				tbl_loc[i]  <= PFIC_LOC_RST;
				pba_loc[i]  <= PFIC_LOC_RST;
				leg_pin[i]  <= 2'h0;
				leg_line[i] <= PFIC_LINE_RST;
				leg_en[i]   <= 1'b0;
			end
		end else if (wr_commit && !refused) begin
			for (int i = 0; i < NUM_PF; i++) begin
				if (sel == 2'(i)) begin
					case (paddr)
						// RULE1 count stored as log2
						PFIC_MSI_CFG_OFS: begin
							msi_log2[i] <= pwdata[2:0];
						end
						// RULE4 RULE5 one table size per PF
						PFIC_TBL_SIZE_OFS: begin
							tbl_size[i] <= pwdata[10:0];
						end
						// RULE6 low three bits carry the BAR index
						PFIC_TBL_CFG_OFS: begin
							tbl_loc[i] <= pwdata;
						end
						// RULE8 pending array offset, same layout
						PFIC_PBA_CFG_OFS: begin
							pba_loc[i] <= pwdata;
						end
						// RULE10 RULE13 pin, line and enable per PF
						PFIC_LEGACY_CFG_OFS: begin
							leg_pin[i]  <= pwdata[1:0];
							leg_line[i] <= pwdata[PFIC_LINE_LSB +: 8];
							leg_en[i]   <= pwdata[PFIC_LEG_EN_BIT];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// illegal counts, bars or an absent function are refused whole
	always_comb begin
		refused = 1'b0;
		// widened: a count of four wraps to zero in two bits
		if ({1'b0, sel} >= 3'(NUM_PF) && paddr >= PFIC_MSI_CFG_OFS
		    && paddr <= PFIC_LEGACY_CFG_OFS)
			refused = 1'b1;
		// RULE1 counts above 32 refused
		if (paddr == PFIC_MSI_CFG_OFS && pwdata[2:0] > PFIC_MMC_MAX)
			refused = 1'b1;
		// RULE7 RULE9 illegal bar index refused
		if ((paddr == PFIC_TBL_CFG_OFS || paddr == PFIC_PBA_CFG_OFS)
		    && !bir_ok(pwdata[2:0], bar64))
			refused = 1'b1;
	end

	// read mux; config space words follow the selected function
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		hit        = ({1'b0, sel} < 3'(NUM_PF));
		case (paddr)
			// RULE2 present on every PF, never on a VF view
			PFIC_MSI_CTRL_OFS: begin
				if (hit && setup[PFIC_MSI_OPT_BIT]
				    && !setup[PFIC_VF_VIEW_BIT]) begin
					next_rdata[PFIC_PRESENT_BIT] = 1'b1;
					next_rdata[PFIC_MMC_LSB +: 3] = msi_log2[sel];
				end
			end
			// RULE3 RULE4 RULE5 VF view shares its PF's table
			PFIC_MSIX_CTRL_OFS: begin
				if (hit && (setup[PFIC_VF_VIEW_BIT] ?
				    setup[PFIC_VF_TBL_OPT_BIT] :
				    setup[PFIC_PF_TBL_OPT_BIT])) begin
					next_rdata[PFIC_PRESENT_BIT] = 1'b1;
					next_rdata[PFIC_TSIZE_LSB +: 11] = tbl_size[sel];
				end
			end
			PFIC_TBL_LOC_OFS: begin
				if (hit)
					next_rdata = tbl_loc[sel];
			end
			PFIC_PBA_LOC_OFS: begin
				if (hit)
					next_rdata = pba_loc[sel];
			end
			PFIC_SETUP_OFS: begin
				next_rdata = setup;
			end
			PFIC_MSI_CFG_OFS: begin
				if (hit)
					next_rdata = {29'h0, msi_log2[sel]};
			end
			PFIC_TBL_SIZE_OFS: begin
				if (hit)
					next_rdata = {21'h0, tbl_size[sel]};
			end
			PFIC_TBL_CFG_OFS: begin
				if (hit)
					next_rdata = tbl_loc[sel];
			end
			PFIC_PBA_CFG_OFS: begin
				if (hit)
					next_rdata = pba_loc[sel];
			end
			PFIC_LEGACY_CFG_OFS: begin
				if (hit)
					next_rdata = {15'h0, leg_en[sel], leg_line[sel],
					              6'h0, leg_pin[sel]};
			end
			PFIC_WIRE_STATE_OFS: begin
				next_rdata = {24'h0, req_sync, wire_sent};
			end
			PFIC_IRQ_STATUS_OFS: begin
				next_rdata = {29'h0, ev_status};
			end
			PFIC_IRQ_MASK_OFS: begin
				next_rdata = {29'h0, ev_mask};
			end
			default: begin
				next_err = 1'b1;
			end
		endcase
	end

	// request pins are asynchronous to clk
	always_ff @(posedge clk) begin
		if (srst) begin
			req_meta <= 4'h0;
			req_sync <= 4'h0;
		end else begin
			req_meta <= {legacy_irq_d_request, legacy_irq_c_request,
			             legacy_irq_b_request, legacy_irq_a_request};
			req_sync <= req_meta;
		end
	end

	// wanted wire level per pin; lowest enabled PF owns the message
	generate
		for (genvar p = 0; p < PFIC_NUM_PINS; p++) begin : g_pin
			logic used;
			always_comb begin
				used = 1'b0;
				pin_func[p] = 2'h0;
				for (int i = NUM_PF - 1; i >= 0; i--) begin
					// RULE12 shared mode puts every PF on pin A
					if (leg_en[i] && (setup[PFIC_SHARED_BIT] ?
					    (p == 0) : (leg_pin[i] == 2'(p)))) begin
						used = 1'b1;
						pin_func[p] = 2'(i);
					end
				end
			end
			// RULE12 shared pin is the OR of all requests
			assign wire_want[p] = used & (setup[PFIC_SHARED_BIT] ?
			                      |req_sync : req_sync[p]);
		end
	endgenerate

	always_comb begin
		next_found = 1'b0;
		next_pin   = 2'h0;
		for (int p = PFIC_NUM_PINS - 1; p >= 0; p--) begin
			if (wire_want[p] != wire_sent[p]) begin
				next_found = 1'b1;
				next_pin   = 2'(p);
			end
		end
	end

	assign busy_free = !msg_valid || msg_ready;

	// RULE11 RULE14 a message only where want and sent differ
	always_ff @(posedge clk) begin
		if (srst) begin
			msg_valid  <= 1'b0;
			msg_assert <= 1'b0;
			msg_pin    <= 2'h0;
			msg_line   <= 8'h00;
			msg_func   <= 2'h0;
			wire_sent  <= 4'h0;
		end else if (busy_free) begin
			msg_valid <= next_found;
			if (next_found) begin
				msg_assert <= wire_want[next_pin];
				msg_pin    <= next_pin;
				// RULE13 line of the owning PF
				msg_line   <= leg_line[pin_func[next_pin]];
				msg_func   <= pin_func[next_pin];
				wire_sent[next_pin] <= wire_want[next_pin];
			end
		end
	end

	// sticky events; a new event beats a same-cycle clear
	always_comb begin
		ev_set = '0;
		ev_set[PFIC_EV_ASSERT]   = msg_valid & msg_ready & msg_assert;
		ev_set[PFIC_EV_DEASSERT] = msg_valid & msg_ready & ~msg_assert;
		ev_set[PFIC_EV_REFUSED]  = wr_commit & refused;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ev_status <= '0;
			ev_mask   <= '0;
			irq       <= 1'b0;
		end else begin
			if (wr_commit && paddr == PFIC_IRQ_STATUS_OFS)
				ev_status <= (ev_status & ~pwdata[PFIC_NUM_EV-1:0]) | ev_set;
			else
				ev_status <= ev_status | ev_set;
			if (wr_commit && paddr == PFIC_IRQ_MASK_OFS)
				ev_mask <= pwdata[PFIC_NUM_EV-1:0];
			irq <= |(ev_status & ev_mask);
		end
	end

	sequence s_rd_msi;
		rd_commit && paddr == PFIC_MSI_CTRL_OFS;
	endsequence
	sequence s_rd_msix;
		rd_commit && paddr == PFIC_MSIX_CTRL_OFS;
	endsequence

	chk_msi_count_range: assert property (@(posedge clk) disable iff (srst) // RULE1
		psel && penable && !pready && paddr == PFIC_MSI_CTRL_OFS
		|=> prdata[PFIC_MMC_LSB +: 3] <= PFIC_MMC_MAX)
		else $error("msi count field above 32");
	chk_msi_all_pf: assert property (@(posedge clk) disable iff (srst) // RULE2
		psel && penable && !pready && paddr == PFIC_MSI_CTRL_OFS
		&& setup[PFIC_MSI_OPT_BIT] && !setup[PFIC_VF_VIEW_BIT]
		&& {1'b0, sel} < 3'(NUM_PF) |=> prdata[PFIC_PRESENT_BIT])
		else $error("msi capability missing on a PF");
	chk_msix_all_pf: assert property (@(posedge clk) disable iff (srst) // RULE3
		psel && penable && !pready && paddr == PFIC_MSIX_CTRL_OFS
		&& setup[PFIC_PF_TBL_OPT_BIT] && !setup[PFIC_VF_VIEW_BIT]
		&& {1'b0, sel} < 3'(NUM_PF) |=> prdata[PFIC_PRESENT_BIT])
		else $error("table capability missing on a PF");
	chk_tsize_field: assert property (@(posedge clk) disable iff (srst) // RULE5
		s_rd_msix |-> prdata[31:27] == 5'h00 && prdata[15:1] == 15'h0)
		else $error("table size outside bits 26:16");
	chk_tbl_bar_legal: assert property (@(posedge clk) disable iff (srst) // RULE7
		rd_commit && paddr == PFIC_TBL_LOC_OFS && $stable(bar64)
		|-> prdata[2:0] <= PFIC_BIR_MAX)
		else $error("table bar index illegal");
	chk_pba_bar_legal: assert property (@(posedge clk) disable iff (srst) // RULE9
		wr_commit && paddr == PFIC_PBA_CFG_OFS && bar64 && pwdata[0]
		|=> ev_status[PFIC_EV_REFUSED])
		else $error("odd pending bar accepted with 64-bit bars");
	chk_msg_hold: assert property (@(posedge clk) disable iff (srst) // RULE11
		msg_valid && !msg_ready |=> msg_valid && $stable(msg_pin)
		&& $stable(msg_assert) && $stable(msg_line))
		else $error("message dropped before accepted");
	chk_msg_level: assert property (@(posedge clk) disable iff (srst) // RULE14
		(!msg_valid || msg_ready) ##1 msg_valid
		|-> wire_sent != $past(wire_sent))
		else $error("message launched with no level change");
	chk_irq_follow: assert property (@(posedge clk) disable iff (srst)
		|(ev_status & ev_mask) |=> irq)
		else $error("irq missing for unmasked event");
	chk_msi_hidden: assert property (@(posedge clk) disable iff (srst) // RULE2
		s_rd_msi ##0 !$past(setup[PFIC_MSI_OPT_BIT]) |-> prdata == 32'h0)
		else $error("msi capability shown while option off");
endmodule

// ==== pfic_pkg.sv ====
package pfic_pkg;
	// register byte offsets
	localparam logic [11:0] PFIC_MSI_CTRL_OFS   = 12'h050;
	localparam logic [11:0] PFIC_MSIX_CTRL_OFS  = 12'h068;
	localparam logic [11:0] PFIC_TBL_LOC_OFS    = 12'h06c;
	localparam logic [11:0] PFIC_PBA_LOC_OFS    = 12'h070;
	localparam logic [11:0] PFIC_SETUP_OFS      = 12'h100;
	localparam logic [11:0] PFIC_MSI_CFG_OFS    = 12'h104;
	localparam logic [11:0] PFIC_TBL_SIZE_OFS   = 12'h108;
	localparam logic [11:0] PFIC_TBL_CFG_OFS    = 12'h10c;
	localparam logic [11:0] PFIC_PBA_CFG_OFS    = 12'h110;
	localparam logic [11:0] PFIC_LEGACY_CFG_OFS = 12'h114;
	localparam logic [11:0] PFIC_WIRE_STATE_OFS = 12'h118;
	localparam logic [11:0] PFIC_IRQ_STATUS_OFS = 12'h120;
	localparam logic [11:0] PFIC_IRQ_MASK_OFS   = 12'h124;
	// field positions
	localparam int PFIC_PRESENT_BIT    = 0;
	localparam int PFIC_MMC_LSB        = 17;
	localparam int PFIC_TSIZE_LSB      = 16;
	localparam int PFIC_SEL_LSB        = 0;
	localparam int PFIC_MSI_OPT_BIT    = 4;
	localparam int PFIC_PF_TBL_OPT_BIT = 5;
	localparam int PFIC_VF_TBL_OPT_BIT = 6;
	localparam int PFIC_SHARED_BIT     = 7;
	localparam int PFIC_BAR64_BIT      = 8;
	localparam int PFIC_VF_VIEW_BIT    = 9;
	localparam int PFIC_LINE_LSB       = 8;
	localparam int PFIC_LEG_EN_BIT     = 16;
	// event bits
	localparam int PFIC_EV_ASSERT  = 0;
	localparam int PFIC_EV_DEASSERT = 1;
	localparam int PFIC_EV_REFUSED = 2;
	localparam int PFIC_NUM_EV     = 3;
	// limits and reset values
	localparam logic [2:0]  PFIC_MMC_MAX      = 3'h5;
	localparam logic [2:0]  PFIC_BIR_MAX      = 3'h5;
	localparam logic [2:0]  PFIC_MMC_RST      = 3'h0;
	localparam logic [10:0] PFIC_TSIZE_RST    = 11'h000;
	localparam logic [31:0] PFIC_LOC_RST      = 32'h0000_0000;
	localparam logic [7:0]  PFIC_LINE_RST     = 8'h00;
	localparam logic [31:0] PFIC_SETUP_RST    = 32'h0000_0000;
	localparam int PFIC_MAX_PF   = 4;
	localparam int PFIC_NUM_PINS = 4;
endpackage

// ==== pfic_link_model.sv ====
`timescale 1ns/100ps
module pfic_link_model (
	// clock
	input  wire logic       clk,
	// message from the block
	input  wire logic       msg_valid,
	input  wire logic       msg_assert,
	input  wire logic [1:0] msg_pin,
	input  wire logic [7:0] msg_line,
	input  wire logic [1:0] msg_func,
	output logic            msg_ready,
	// bench control
	input  wire logic       stall
);
	int          count;
	logic [12:0] last;
	initial begin
		count = 0;
		last = '0;
		msg_ready = 1'b0;
	end
	// take one message a handshake
	// ready is registered, so a stall shows a cycle late
	always @(posedge clk) begin
		msg_ready <= !stall;
		if (msg_valid && msg_ready) begin
			count <= count + 1;
			last <= {msg_assert, msg_pin, msg_line, msg_func};
		end
	end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	import pfic_pkg::*;
	logic        clk, srst, psel, penable, pwrite, stall, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, msg_valid, msg_ready, msg_assert, irq;
	logic [3:0]  req;
	logic [1:0]  msg_pin, msg_func;
	logic [7:0]  msg_line;
	int          fails, compares, c0, pf, k;
	pfic_top #(.NUM_PF(4)) pfic_top_inst (.clk(clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .legacy_irq_a_request(req[0]),
		.legacy_irq_b_request(req[1]), .legacy_irq_c_request(req[2]),
		.legacy_irq_d_request(req[3]), .msg_valid(msg_valid),
		.msg_ready(msg_ready), .msg_assert(msg_assert),
		.msg_pin(msg_pin), .msg_line(msg_line), .msg_func(msg_func),
		.irq(irq));
	pfic_link_model pfic_link_model_inst (.clk(clk),
		.msg_valid(msg_valid), .msg_assert(msg_assert),
		.msg_pin(msg_pin), .msg_line(msg_line), .msg_func(msg_func),
		.msg_ready(msg_ready), .stall(stall));
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	task automatic end_of_test();
		$display("counts: compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			$display("MISMATCH t=%0t bus timeout", $time);
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "read");
	endtask
	// waits for the far side to count one more message
	task automatic wait_msg();
		int n;
		n = 0;
		while (pfic_link_model_inst.count == c0 && n < 30) begin
			@(posedge clk);
			n++;
		end
		if (pfic_link_model_inst.count == c0) begin
			fails++;
			$display("MISMATCH t=%0t no message", $time);
			end_of_test();
		end
	endtask
	task automatic t_reset();
		rdc(PFIC_MSI_CTRL_OFS, 32'h0);
		rdc(PFIC_MSIX_CTRL_OFS, 32'h0);
		rdc(PFIC_TBL_LOC_OFS, 32'h0);
		rdc(PFIC_PBA_LOC_OFS, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_msi();
		for (k = 0; k < 6; k++) begin
			apb(1'b1, PFIC_SETUP_OFS, 32'h10);
			apb(1'b1, PFIC_MSI_CFG_OFS, k);
			rdc(PFIC_MSI_CTRL_OFS, (k << 17) | 1);
		end
		apb(1'b1, PFIC_MSI_CFG_OFS, 32'h6);
		rdc(PFIC_MSI_CTRL_OFS, 32'h000a_0001);
		for (pf = 0; pf < 4; pf++) begin
			apb(1'b1, PFIC_SETUP_OFS, 32'h10 | pf);
			apb(1'b1, PFIC_MSI_CFG_OFS, pf);
		end
		for (pf = 0; pf < 4; pf++) begin
			apb(1'b1, PFIC_SETUP_OFS, 32'h10 | pf);
			rdc(PFIC_MSI_CTRL_OFS, (pf << 17) | 1);
		end
		$display("test msi done");
	endtask
	task automatic t_msix();
		apb(1'b1, PFIC_IRQ_STATUS_OFS, 32'h4);
		apb(1'b1, PFIC_SETUP_OFS, 32'h20);
		apb(1'b1, PFIC_TBL_SIZE_OFS, 32'h7ff);
		apb(1'b1, PFIC_MSIX_CTRL_OFS, 32'h0);
		rdc(PFIC_MSIX_CTRL_OFS, 32'h07ff_0001);
		apb(1'b1, PFIC_TBL_CFG_OFS, 32'h0000_1235);
		rdc(PFIC_TBL_LOC_OFS, 32'h0000_1235);
		apb(1'b1, PFIC_SETUP_OFS, 32'h120);
		apb(1'b1, PFIC_TBL_CFG_OFS, 32'h0000_2003);
		rdc(PFIC_TBL_LOC_OFS, 32'h0000_1235);
		apb(1'b1, PFIC_PBA_CFG_OFS, 32'h0000_4004);
		rdc(PFIC_PBA_LOC_OFS, 32'h0000_4004);
		apb(1'b1, PFIC_PBA_CFG_OFS, 32'h0000_8001);
		rdc(PFIC_PBA_LOC_OFS, 32'h0000_4004);
		rdc(PFIC_IRQ_STATUS_OFS, 32'h4);
		chk({31'h0, irq}, 32'h0, "masked irq");
		apb(1'b1, PFIC_SETUP_OFS, 32'h270);
		rdc(PFIC_MSIX_CTRL_OFS, 32'h07ff_0001);
		rdc(PFIC_MSI_CTRL_OFS, 32'h0);
		apb(1'b1, PFIC_IRQ_STATUS_OFS, 32'h4);
		$display("test msix done");
	endtask
	// one legacy edge on pin p, then the message fields
	task automatic edge_msg(input int p, input logic v,
			input logic [12:0] e);
		c0 = pfic_link_model_inst.count;
		req[p] <= v;
		wait_msg();
		chk(pfic_link_model_inst.last, e, "message");
	endtask
	task automatic t_legacy();
		apb(1'b1, PFIC_SETUP_OFS, 32'h0);
		apb(1'b1, PFIC_LEGACY_CFG_OFS, 32'h0001_2a00);
		apb(1'b1, PFIC_SETUP_OFS, 32'h1);
		apb(1'b1, PFIC_LEGACY_CFG_OFS, 32'h0001_5502);
		apb(1'b1, PFIC_IRQ_MASK_OFS, 32'h3);
		stall <= 1'b1;
		c0 = pfic_link_model_inst.count;
		req[0] <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, msg_valid}, 32'h1, "held");
		stall <= 1'b0;
		wait_msg();
		chk(pfic_link_model_inst.last, 13'h10a8, "assert");
		repeat (10) @(posedge clk);
		chk(pfic_link_model_inst.count, c0 + 1, "once");
		chk({31'h0, irq}, 32'h1, "irq");
		apb(1'b1, PFIC_IRQ_STATUS_OFS, 32'h1);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq clr");
		edge_msg(0, 1'b0, 13'h00a8);
		edge_msg(2, 1'b1, 13'h1955);
		edge_msg(2, 1'b0, 13'h0955);
		c0 = pfic_link_model_inst.count;
		req[1] <= 1'b1;
		repeat (10) @(posedge clk);
		chk(pfic_link_model_inst.count, c0, "unused pin");
		req[1] <= 1'b0;
		repeat (10) @(posedge clk);
		apb(1'b1, PFIC_SETUP_OFS, 32'h80);
		edge_msg(3, 1'b1, 13'h10a8);
		rdc(PFIC_WIRE_STATE_OFS, 32'h81);
		edge_msg(3, 1'b0, 13'h00a8);
		rdc(PFIC_IRQ_STATUS_OFS, 32'h3);
		rdc(PFIC_WIRE_STATE_OFS, 32'h0);
		$display("test legacy done");
	endtask
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		req = '0;
		stall = 1'b0;
		fails = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_msi();
		t_msix();
		t_legacy();
		end_of_test();
	end
endmodule
